// >>> rtcf_reset_seq.v
// Reset sequencer with reset-cause flags, watchdog and AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "rtcf_map.vh"


module rtcf_reset_seq #(
	parameter CNT_W = 25,
	parameter [CNT_W-1:0] POWER_UP_DELAY_TIMER_CYCLES = `RTCF_POWER_UP_DELAY_TIMER_CYCLES,
	parameter [CNT_W-1:0] OST_CYCLES = `RTCF_OST_CYCLES,
	parameter WDT_PRE_W = 7,
	parameter WDT_CNT_W = 8
) (
	// Clock and power-on reset.
	input wire i_sys_clk,
	input wire i_rst,
	// Supply monitor, pin and configuration word.
	input wire i_brown_out,
	input wire i_master_clear_n,
	input wire i_power_up_timer_enable_n,
	input wire i_brown_out_detect_enable,
	input wire i_watchdog_enable,
	input wire [1:0] i_osc_mode,
	// Core events and the watchdog RC oscillator tick.
	input wire i_watchdog_clear_instruction,
	input wire i_sleep_instruction,
	input wire i_wake_interrupt,
	input wire i_watchdog_rc_tick,
	// Sequencer outputs.
	output reg o_core_reset,
	output reg o_sleeping,
	output reg o_watchdog_timeout,
	// AXI4-Lite write channels.
	input wire [13:0] i_awaddr,
	input wire i_awvalid,
	output reg o_awready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	input wire i_wvalid,
	output reg o_wready,
	output reg [1:0] o_bresp,
	output reg o_bvalid,
	input wire i_bready,
	// AXI4-Lite read channels.
	input wire [13:0] i_araddr,
	input wire i_arvalid,
	output reg o_arready,
	output reg [31:0] o_rdata,
	output reg [1:0] o_rresp,
	output reg o_rvalid,
	input wire i_rready
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [6:0] ST_START = 7'b0000001;
	localparam [6:0] ST_POWER_UP_DELAY_TIMER = 7'b0000010;
	localparam [6:0] ST_OST = 7'b0000100;
	localparam [6:0] ST_BOR = 7'b0001000;
	localparam [6:0] ST_RUN = 7'b0010000;
	localparam [6:0] ST_SLEEP = 7'b0100000;
	localparam [6:0] ST_WAKE = 7'b1000000;
	localparam [CNT_W-1:0] CNT_ONE = 1;
	localparam [CNT_W-1:0] CNT_ZERO = 0;

	reg [6:0] state;
	reg [CNT_W-1:0] count;
	reg [6:0] next_state;
	reg [CNT_W-1:0] next_count;
	reg timeout_flag;
	reg powerdown_flag;
	reg power_on_flag;
	reg brown_out_flag;
	reg [WDT_PRE_W-1:0] wdt_pre;
	reg [WDT_CNT_W-1:0] wdt_cnt;
	wire crystal;
	wire brown_evt;
	wire in_reset;
	wire [CNT_W-1:0] ost_load;

	// Brown-out is only heeded while the detector is enabled.
	assign brown_evt = i_brown_out & i_brown_out_detect_enable;
	assign crystal = (i_osc_mode != `RTCF_OSC_RC);
	// RC mode has no start-up timer; a single cycle still pulses reset.
	assign ost_load = crystal ? OST_CYCLES : CNT_ONE;
	assign in_reset = (state == ST_START) | (state == ST_POWER_UP_DELAY_TIMER) | (state == ST_OST) | (state == ST_BOR);

	// ----------------------------------------
	// Sequencer next state
	// ----------------------------------------

	// The delay counters run whatever master clear does, so a pin held low
	// past expiry leaves nothing to wait for once it is released.
	always @* begin
		next_state = state;
		next_count = (count != CNT_ZERO) ? count - CNT_ONE : CNT_ZERO;
		case (state)
			ST_START: begin
				if (!i_power_up_timer_enable_n) begin
					next_state = ST_POWER_UP_DELAY_TIMER;
					next_count = POWER_UP_DELAY_TIMER_CYCLES;
				end else if (crystal) begin
					next_state = ST_OST;
					next_count = OST_CYCLES;
				end else begin
					next_state = ST_RUN;
				end
			end
			ST_POWER_UP_DELAY_TIMER: begin
				if (brown_evt) begin
					next_state = ST_BOR;
				end else if (count == CNT_ONE) begin
					next_state = crystal ? ST_OST : ST_RUN;
					next_count = crystal ? OST_CYCLES : CNT_ZERO;
				end
			end
			ST_OST: begin
				if (brown_evt) begin
					next_state = ST_BOR;
				end else if (count == CNT_ONE) begin
					next_state = ST_RUN;
				end
			end
			ST_BOR: begin
				// The full delay restarts once the supply recovers.
				if (!brown_evt) begin
					next_state = ST_POWER_UP_DELAY_TIMER;
					next_count = POWER_UP_DELAY_TIMER_CYCLES;
				end
			end
			ST_RUN: begin
				if (brown_evt) begin
					next_state = ST_BOR;
				end else if (o_watchdog_timeout) begin
					next_state = ST_OST;
					next_count = ost_load;
				end else if (i_sleep_instruction && i_master_clear_n) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (brown_evt) begin
					next_state = ST_BOR;
				end else if (!i_master_clear_n) begin
					next_state = ST_OST;
					next_count = ost_load;
				end else if (o_watchdog_timeout || i_wake_interrupt) begin
					next_state = crystal ? ST_WAKE : ST_RUN;
					next_count = crystal ? OST_CYCLES : CNT_ZERO;
				end
			end
			ST_WAKE: begin
				if (brown_evt) begin
					next_state = ST_BOR;
				end else if (!i_master_clear_n) begin
					// Reload the count: a partly spent wake count could reach zero and stall.
					next_state = ST_OST;
					next_count = ost_load;
				end else if (count == CNT_ONE) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_START;
				next_count = CNT_ZERO;
			end
		endcase
	end

	// ----------------------------------------
	// Sequencer registers
	// ----------------------------------------

	// The core reset is released only when the pin is high and the next state is none of power-up delay, start-up or brown-out.
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_START;
			count <= {CNT_W{1'b0}};
			o_core_reset <= 1'b1;
			o_sleeping <= 1'b0;
		end else begin
			state <= next_state;
			count <= next_count;
			o_core_reset <= ~i_master_clear_n | (next_state == ST_POWER_UP_DELAY_TIMER) | (next_state == ST_OST) |
				(next_state == ST_BOR);
			o_sleeping <= (next_state == ST_SLEEP) | (next_state == ST_WAKE);
		end
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------

	// The tick comes from the watchdog's own RC oscillator, so the timeout
	// still fires in sleep while the main core is stopped.
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			wdt_pre <= {WDT_PRE_W{1'b0}};
			wdt_cnt <= {WDT_CNT_W{1'b0}};
			o_watchdog_timeout <= 1'b0;
		end else if (in_reset || !i_watchdog_enable || o_core_reset ||
			(state == ST_RUN && i_watchdog_clear_instruction)) begin
			wdt_pre <= {WDT_PRE_W{1'b0}};
			wdt_cnt <= {WDT_CNT_W{1'b0}};
			o_watchdog_timeout <= 1'b0;
		end else begin
			o_watchdog_timeout <= 1'b0;
			if (i_watchdog_rc_tick) begin
				wdt_pre <= wdt_pre + {{(WDT_PRE_W-1){1'b0}}, 1'b1};
				if (&wdt_pre) begin
					wdt_cnt <= wdt_cnt + {{(WDT_CNT_W-1){1'b0}}, 1'b1};
					o_watchdog_timeout <= &wdt_cnt;
				end
			end
		end
	end

	// ----------------------------------------
	// Bus write side
	// ----------------------------------------
	reg aw_held;
	reg w_held;
	reg [11:0] aw_idx;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire wr_do;
	wire power_control_flags_wr;

	assign wr_do = aw_held & w_held & ~o_bvalid;
	assign power_control_flags_wr = wr_do & (aw_idx == `RTCF_IDX_POWER_CTRL) & w_strb[0];

	// Address and data are taken in either order and joined before the write.
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			o_awready <= 1'b1;
			o_wready <= 1'b1;
			o_bvalid <= 1'b0;
			o_bresp <= `RTCF_RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held <= 1'b1;
				aw_idx <= i_awaddr[13:`RTCF_ADDR_LSB];
				o_awready <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
				o_wready <= 1'b0;
			end
			if (wr_do) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= ((aw_idx == `RTCF_IDX_POWER_CTRL) || (aw_idx == `RTCF_IDX_CORE_STATUS) ||
					(aw_idx == `RTCF_IDX_SEQ_STATE)) ? `RTCF_RESP_OKAY : `RTCF_RESP_SLVERR;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
				o_awready <= 1'b1;
				o_wready <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Reset-cause flags
	// ----------------------------------------

	// The async reset is the power-on reset: timeout and power-down set,
	// power-on flag cleared. Hardware clears win over a software write of one.
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			timeout_flag <= `RTCF_RST_TIMEOUT;
			powerdown_flag <= `RTCF_RST_POWERDOWN;
			power_on_flag <= `RTCF_RST_POWER_ON;
			brown_out_flag <= `RTCF_RST_BROWN_OUT;
		end else begin
			// Power-on flag changes only by software after power-on.
			if (power_control_flags_wr) begin
				power_on_flag <= w_data[`RTCF_BIT_POWER_ON];
			end
			if (brown_evt && state != ST_BOR) begin
				brown_out_flag <= 1'b0;
			end else if (power_control_flags_wr) begin
				brown_out_flag <= w_data[`RTCF_BIT_BROWN_OUT];
			end
			// Watchdog events outrank the clear instruction in the same cycle, except in run during a brown-out.
			if (o_watchdog_timeout && state == ST_SLEEP) begin
				timeout_flag <= 1'b0;
				powerdown_flag <= 1'b0;
			end else if (o_watchdog_timeout && state == ST_RUN && !brown_evt) begin
				timeout_flag <= 1'b0;
			end else if (state == ST_RUN && i_watchdog_clear_instruction) begin
				timeout_flag <= 1'b1;
				powerdown_flag <= 1'b1;
			end else if (next_state == ST_SLEEP && state == ST_RUN) begin
				// Sleep entry leaves the pattern a master clear in sleep keeps.
				timeout_flag <= 1'b1;
				powerdown_flag <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Bus read side
	// ----------------------------------------
	reg [31:0] rd_word;
	reg rd_hit;

	// Unimplemented bits read as zero; the status word holds only two flags.
	always @* begin
		rd_word = 32'h0000_0000;
		rd_hit = 1'b1;
		case (i_araddr[13:`RTCF_ADDR_LSB])
			`RTCF_IDX_CORE_STATUS: begin
				rd_word[`RTCF_BIT_TIMEOUT] = timeout_flag;
				rd_word[`RTCF_BIT_POWERDOWN] = powerdown_flag;
			end
			`RTCF_IDX_POWER_CTRL: begin
				rd_word[`RTCF_BIT_POWER_ON] = power_on_flag;
				rd_word[`RTCF_BIT_BROWN_OUT] = brown_out_flag;
			end
			`RTCF_IDX_SEQ_STATE: begin
				rd_word[6:0] = state;
				rd_word[7] = o_core_reset;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// One read at a time; the answer stands until the master takes it.
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			o_arready <= 1'b1;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `RTCF_RESP_OKAY;
		end else begin
			if (i_arvalid && o_arready) begin
				o_arready <= 1'b0;
				o_rvalid <= 1'b1;
				o_rdata <= rd_word;
				o_rresp <= rd_hit ? `RTCF_RESP_OKAY : `RTCF_RESP_SLVERR;
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
				o_arready <= 1'b1;
			end
		end
	end

endmodule // rtcf_reset_seq

// >>> rtcf_map.vh
// Register map, field positions, reset values and timing constants of the reset sequencer.
`ifndef RTCF_MAP_VH
`define RTCF_MAP_VH

// ----------------------------------------
// Register indices (byte address is index times four)
// ----------------------------------------
`define RTCF_IDX_CORE_STATUS 12'h083
`define RTCF_IDX_POWER_CTRL 12'h08E
`define RTCF_IDX_SEQ_STATE 12'h090
`define RTCF_ADDR_LSB 2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTCF_BIT_TIMEOUT 4
`define RTCF_BIT_POWERDOWN 3
`define RTCF_BIT_POWER_ON 1
`define RTCF_BIT_BROWN_OUT 0

// ----------------------------------------
// Reset values of the flags
// ----------------------------------------
`define RTCF_RST_TIMEOUT 1'b1
`define RTCF_RST_POWERDOWN 1'b1
`define RTCF_RST_POWER_ON 1'b0
`define RTCF_RST_BROWN_OUT 1'b0

// ----------------------------------------
// Oscillator modes
// ----------------------------------------
`define RTCF_OSC_LP 2'h0
`define RTCF_OSC_XT 2'h1
`define RTCF_OSC_HS 2'h2
`define RTCF_OSC_RC 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define RTCF_CLK_MHZ 250
`define RTCF_POWER_UP_DELAY_TIMER_MS 72
`define RTCF_POWER_UP_DELAY_TIMER_CYCLES (`RTCF_POWER_UP_DELAY_TIMER_MS * 1000 * `RTCF_CLK_MHZ)
`define RTCF_OST_CYCLES 1024

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define RTCF_RESP_OKAY 2'h0
`define RTCF_RESP_SLVERR 2'h2

`endif

// >>> rtcf_env_model.sv
// Behavioural model of the supply monitor, the reset pin and the watchdog RC oscillator.
`timescale 1ns/1ps

module rtcf_env_model (
	// Clock.
	input wire i_sys_clk,
	// Requests from the bench.
	input wire i_sag,
	input wire i_press,
	// Lines into the sequencer.
	output reg o_brown_out = 1'b0,
	output reg o_master_clear_n = 1'b1,
	output reg o_watchdog_rc_tick = 1'b0
);
	reg [1:0] rc_div = 2'h0;

	// Monitor and pin react one cycle late, so the block never sees a same-edge change.
	always @(posedge i_sys_clk) begin
		o_brown_out <= i_sag;
		o_master_clear_n <= !i_press;
	end

	// The RC oscillator runs free of any reset, one tick every fourth cycle.
	always @(posedge i_sys_clk) begin
		rc_div <= rc_div + 2'h1;
		o_watchdog_rc_tick <= (rc_div == 2'h3);
	end
endmodule // rtcf_env_model

// >>> rtcf_reset_seq_sva.sv
// Concurrent checks on the reset sequencer ports, bound into the design.
`timescale 1ns/1ps
`include "rtcf_map.vh"

module rtcf_reset_seq_sva #(
	parameter int POWER_UP_DELAY_TIMER_CYCLES = 40
) (
	// Clock and reset.
	input wire i_sys_clk,
	input wire i_rst,
	// Supply, pin and configuration.
	input wire i_brown_out,
	input wire i_brown_out_detect_enable,
	input wire i_master_clear_n,
	input wire i_power_up_timer_enable_n,
	input wire [1:0] i_osc_mode,
	// Sequencer outputs.
	input wire o_core_reset,
	input wire o_sleeping,
	input wire o_watchdog_timeout,
	// Register bus.
	input wire i_awvalid,
	input wire o_awready,
	input wire i_wvalid,
	input wire o_wready,
	input wire o_bvalid,
	input wire [13:0] i_araddr,
	input wire i_arvalid,
	input wire o_arready,
	input wire o_rvalid,
	input wire [31:0] o_rdata
);
	reg bo_seen;
	reg [31:0] quiet;

	// Cycles since the supply last sagged; an early release after a sag is what we must catch.
	always @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			bo_seen <= 1'b0;
			quiet <= 32'h0;
		end else if (i_brown_out && i_brown_out_detect_enable) begin
			bo_seen <= 1'b1;
			quiet <= 32'h0;
		end else begin
			quiet <= quiet + 32'h1;
			if (!o_core_reset) bo_seen <= 1'b0;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence aw_w_taken;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence

	sequence ar_taken;
		i_arvalid && o_arready;
	endsequence

	a_pin_holds_reset:
		assert property (!i_master_clear_n ##1 !i_master_clear_n |=> o_core_reset)
		else $error("reset lifted with pin low");
	a_sag_holds_reset:
		assert property (i_brown_out && i_brown_out_detect_enable ##1 i_brown_out |=> o_core_reset)
		else $error("reset lifted during sag");
	a_sag_min_hold:
		assert property ($fell(o_core_reset) && bo_seen |-> quiet >= POWER_UP_DELAY_TIMER_CYCLES - 1)
		else $error("sag reset too short");
	a_rc_no_delay:
		assert property ($fell(i_rst) && i_osc_mode == `RTCF_OSC_RC && i_power_up_timer_enable_n
			&& i_master_clear_n && !i_brown_out |-> ##[1:3] !o_core_reset)
		else $error("RC start without timer delayed");
	a_dog_run_reset:
		assert property (o_watchdog_timeout && !o_sleeping |-> ##[0:1] o_core_reset)
		else $error("watchdog overflow gave no reset");
	a_write_answer:
		assert property (aw_w_taken |=> ##1 o_bvalid)
		else $error("write response late");
	a_read_answer:
		assert property (ar_taken |=> o_rvalid)
		else $error("read response late");
	a_power_control_flags_high_zero:
		assert property (ar_taken ##0 i_araddr == (`RTCF_IDX_POWER_CTRL << `RTCF_ADDR_LSB) |=> o_rdata[31:2] == 30'h0)
		else $error("power control upper bits set");
endmodule // rtcf_reset_seq_sva

bind rtcf_reset_seq rtcf_reset_seq_sva #(.POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)) rtcf_reset_seq_sva_inst (.i_sys_clk, .i_rst,
	.i_brown_out, .i_brown_out_detect_enable, .i_master_clear_n, .i_power_up_timer_enable_n, .i_osc_mode,
	.o_core_reset, .o_sleeping, .o_watchdog_timeout, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid,
	.i_araddr, .i_arvalid, .o_arready, .o_rvalid, .o_rdata);

// >>> rtcf_reset_seq_tb.sv
// Self-checking bench for the reset sequencer and its cause flags.
`timescale 1ns/1ps
`include "rtcf_map.vh"

module rtcf_reset_seq_tb;
	localparam int P = 40;
	localparam int O = 8;
	localparam [13:0] st_a = `RTCF_IDX_CORE_STATUS << `RTCF_ADDR_LSB;
	localparam [13:0] pc_a = `RTCF_IDX_POWER_CTRL << `RTCF_ADDR_LSB;
	localparam [13:0] sq_a = `RTCF_IDX_SEQ_STATE << `RTCF_ADDR_LSB;
	reg clk = 1'b0, rst = 1'b1, sag = 1'b0, press = 1'b0, en_n = 1'b0, bod = 1'b1, wdt = 1'b0;
	reg slp = 1'b0, clr = 1'b0, wake = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	reg arvalid = 1'b0, rready = 1'b0;
	reg [1:0] osc = `RTCF_OSC_XT;
	reg [3:0] strb = 4'hF;
	reg [13:0] awaddr = 14'h0000, araddr = 14'h0000;
	reg [31:0] wdata = 32'h0000_0000, d;
	wire bo, master_clear_n_n, tick, core_rst, sleeping, wto, awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	integer failures = 0, samples_checked = 0, cycles = 0;

	// ------
	// Clock, partner and design
	// ------
	initial begin
		forever #2 clk = ~clk;
	end

	rtcf_env_model rtcf_env_model_inst (.i_sys_clk(clk), .i_sag(sag), .i_press(press), .o_brown_out(bo),
		.o_master_clear_n(master_clear_n_n), .o_watchdog_rc_tick(tick));

	// Short counts keep the run small; every expected span except pin_late and the RC start without the timer is derived from P and O.
	rtcf_reset_seq #(.POWER_UP_DELAY_TIMER_CYCLES(P), .OST_CYCLES(O), .WDT_PRE_W(1), .WDT_CNT_W(2)) rtcf_reset_seq_inst (
		.i_sys_clk(clk), .i_rst(rst), .i_brown_out(bo), .i_master_clear_n(master_clear_n_n),
		.i_power_up_timer_enable_n(en_n), .i_brown_out_detect_enable(bod), .i_watchdog_enable(wdt),
		.i_osc_mode(osc), .i_watchdog_clear_instruction(clr), .i_sleep_instruction(slp), .i_wake_interrupt(wake),
		.i_watchdog_rc_tick(tick), .o_core_reset(core_rst), .o_sleeping(sleeping), .o_watchdog_timeout(wto),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(strb),
		.i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready));

	// Cut a hang short; the whole run needs under two thousand cycles.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			failures = failures + 1;
			end_of_test();
		end
	end

	// ------
	// Tasks
	// ------
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked = samples_checked + 1;
		if (g !== e) begin
			failures = failures + 1;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Each bus task ends one edge after its handshake, so no strobe is driven twice in a step.
	task automatic axw(input logic [13:0] a, input logic [31:0] v, input logic [1:0] er);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge clk);
	endtask

	task automatic axr(input logic [13:0] a, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge clk);
	endtask

	task automatic st(input logic [1:0] e);
		axr(st_a, `RTCF_RESP_OKAY);
		chk("status", {30'h0, e}, {30'h0, d[4:3]});
	endtask

	task automatic pc(input logic [31:0] e, input logic [31:0] m);
		axr(pc_a, `RTCF_RESP_OKAY);
		chk("power_control_flags", e, d & m);
	endtask

	task automatic span(input string nm, input int lo, input int hi);
		int n;
		n = 0;
		while (core_rst !== 1'b0 && n < 400) begin
			@(posedge clk);
			n = n + 1;
		end
		samples_checked = samples_checked + 1;
		if (n < lo || n > hi) begin
			failures = failures + 1;
			$display("FAIL %s expected %0d to %0d seen %0d", nm, lo, hi, n);
		end
	endtask

	task automatic por(input logic [1:0] m, input logic e, input int lo, input int hi);
		osc <= m;
		en_n <= e;
		rst <= 1'b1;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		if (hi > 0) span("startup", lo, hi);
	endtask

	// Core event pulse: 0 sleep, 1 watchdog clear, 2 interrupt.
	task automatic op(input int k);
		slp <= (k == 0);
		clr <= (k == 1);
		wake <= (k == 2);
		@(posedge clk);
		{slp, clr, wake} <= 3'b000;
		repeat (3) @(posedge clk);
	endtask

	task automatic wt(input logic awake);
		int n;
		n = 0;
		while ((awake ? sleeping !== 1'b0 : wto !== 1'b1) && n < 300) begin
			@(posedge clk);
			n = n + 1;
		end
		chk("wait_bound", 32'h0, {31'h0, n == 300});
	endtask

	task automatic pin(input string nm);
		press <= 1'b1;
		repeat (4) @(posedge clk);
		press <= 1'b0;
		span(nm, 0, O + 4);
	endtask

	// ------
	// Tests
	// ------
	initial begin
		por(`RTCF_OSC_XT, 1'b0, P + O, P + O + 4);
		st(2'b11);
		pc(32'h0, 32'hFFFF_FFFE);
		axr(14'h0100, `RTCF_RESP_SLVERR);
		chk("unmapped", 32'h0, d);
		axw(pc_a, 32'hFFFF_FFFF, `RTCF_RESP_OKAY);
		pc(32'h3, 32'hFFFF_FFFF);
		strb <= 4'hE;
		axw(pc_a, 32'h0000_0000, `RTCF_RESP_OKAY);
		strb <= 4'hF;
		pc(32'h3, 32'hFFFF_FFFF);
		axw(14'h0100, 32'h0000_0000, `RTCF_RESP_SLVERR);
		axr(sq_a, `RTCF_RESP_OKAY);
		chk("seq_state", 32'h0000_0010, d);
		axw(st_a, 32'h0000_0000, `RTCF_RESP_OKAY);
		st(2'b11);
		$display("test power_on done");
		sag <= 1'b1;
		repeat (5) @(posedge clk);
		sag <= 1'b0;
		span("brown_out", P + O, P + O + 6);
		pc(32'h2, 32'hFFFF_FFFF);
		st(2'b11);
		axw(pc_a, 32'h0000_0003, `RTCF_RESP_OKAY);
		bod <= 1'b0;
		sag <= 1'b1;
		repeat (5) @(posedge clk);
		chk("bod_off", 32'h0, {31'h0, core_rst});
		sag <= 1'b0;
		repeat (3) @(posedge clk);
		bod <= 1'b1;
		$display("test brown_out done");
		op(0);
		chk("asleep", 32'h1, {31'h0, sleeping});
		st(2'b10);
		op(2);
		wt(1'b1);
		chk("no_reset", 32'h0, {31'h0, core_rst});
		op(0);
		pin("pin_sleep");
		st(2'b10);
		op(0);
		wake <= 1'b1;
		press <= 1'b1;
		@(posedge clk);
		wake <= 1'b0;
		repeat (3) @(posedge clk);
		press <= 1'b0;
		span("pin_wake", O - 1, O + 1);
		st(2'b10);
		op(1);
		st(2'b11);
		pin("pin_run");
		st(2'b11);
		pc(32'h3, 32'hFFFF_FFFF);
		$display("test sleep_and_pin done");
		wdt <= 1'b1;
		op(0);
		wt(1'b0);
		wt(1'b1);
		st(2'b00);
		op(1);
		st(2'b11);
		wt(1'b0);
		wdt <= 1'b0;
		@(posedge clk);
		span("watchdog", O - 2, O + 4);
		st(2'b01);
		$display("test watchdog done");
		por(`RTCF_OSC_LP, 1'b0, P + O, P + O + 4);
		por(`RTCF_OSC_HS, 1'b1, O, O + 4);
		por(`RTCF_OSC_RC, 1'b0, P, P + 4);
		por(`RTCF_OSC_RC, 1'b1, 0, 3);
		press <= 1'b1;
		por(`RTCF_OSC_XT, 1'b0, 0, 0);
		repeat (P + O + 20) @(posedge clk);
		chk("pin_hold", 32'h1, {31'h0, core_rst});
		axr(sq_a, `RTCF_RESP_OKAY);
		chk("seq_hold", 32'h0000_0090, d);
		press <= 1'b0;
		span("pin_late", 0, 4);
		pc(32'h0, 32'hFFFF_FFFE);
		$display("test resets done");
		end_of_test();
	end
endmodule // rtcf_reset_seq_tb
